// ===== common/isr_defs.svh
/*
  Constants for the status reporting block: widths, bit positions,
  register selects, zero masks and reset values.
  Assumes it is included by bare name after `default_nettype none.
*/
`ifndef ISR_DEFS_SVH
`define ISR_DEFS_SVH

// ----------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------
`define ISR_WIDE 16
`define ISR_NARROW 8
`define ISR_RST_WORD 16'h0000
`define ISR_RST_BYTE 8'h00
`define ISR_PAD_BYTE 8'h00

// ----------------------------------------------------------------
// Run-state bit positions
// ----------------------------------------------------------------
`define ISR_OPER_WAIT 5
`define ISR_OPER_ARMED 6
`define ISR_OPER_CV 8
`define ISR_OPER_TDONE 9
`define ISR_OPER_CC 10
`define ISR_OPER_SAMPLE 11
`define ISR_OPER_LDONE 12
`define ISR_OPER_LRUN 14
// Bits 0-4, 7, 13, 15 always zero
`define ISR_OPER_ZERO 16'ha09f
// Bits 9 and 12 live only on the event path
`define ISR_OPER_EVONLY 16'h1200

// ----------------------------------------------------------------
// Quality fault bit positions
// ----------------------------------------------------------------
`define ISR_QUES_CM 0
`define ISR_QUES_VM 1
`define ISR_QUES_THERM 3
`define ISR_QUES_SLAVE 6
`define ISR_QUES_VPROT 12
`define ISR_QUES_CPROT 13
`define ISR_QUES_SINK 14
// Bits 2, 4, 5, 7-11, 15 always zero
`define ISR_QUES_ZERO 16'h8fb4

// ----------------------------------------------------------------
// Status byte bit positions
// ----------------------------------------------------------------
`define ISR_SB_ERR 3
`define ISR_SB_MAV 4
`define ISR_SB_ESB 5
`define ISR_SB_RQS 6
`define ISR_SB_OPER 7
`define ISR_SB_LOW_ZERO 3'h0
`define ISR_SB_RQS_OFF 8'hbf

// ----------------------------------------------------------------
// Register selects on the access port
// ----------------------------------------------------------------
`define ISR_SEL_OPER_COND 4'h0
`define ISR_SEL_OPER_EVT 4'h1
`define ISR_SEL_OPER_EN 4'h2
`define ISR_SEL_QUES_COND 4'h3
`define ISR_SEL_QUES_EVT 4'h4
`define ISR_SEL_QUES_EN 4'h5
`define ISR_SEL_STD_COND 4'h6
`define ISR_SEL_STD_EVT 4'h7
`define ISR_SEL_STD_EN 4'h8
`define ISR_SEL_SB_COND 4'h9
`define ISR_SEL_SB_EVT 4'ha
`define ISR_SEL_SB_EN 4'hb

`endif

// ===== common/isr_pkg.sv
/*
  Types shared by the status reporting design files.
  Assumes isr_defs.svh supplies the widths.
*/
`default_nettype none
`include "isr_defs.svh"

package isr_pkg;
  // Sixteen-bit register word
  typedef logic [`ISR_WIDE-1:0] isr_word_t;
  // Eight-bit register byte
  typedef logic [`ISR_NARROW-1:0] isr_byte_t;
  // Register select code
  typedef logic [3:0] isr_sel_t;
endpackage : isr_pkg

`default_nettype wire

// ===== hdl/isr_group.sv
/*
  One status group: condition, transition-latched event and enable
  mask, with a summary of enabled events.
  Assumes a single clock; read-clear and write strobes are one cycle.
*/
`timescale 1ns/1ps
`default_nettype none
`include "isr_defs.svh"

module isr_group #(
  parameter int W = `ISR_WIDE
) (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic [W-1:0] i_cond,
  input wire logic [W-1:0] i_pulse,
  input wire logic i_clr,
  input wire logic i_wr,
  input wire logic [W-1:0] i_wr_data,
  output logic [W-1:0] o_cond,
  output logic [W-1:0] o_event,
  output logic [W-1:0] o_enable,
  output logic o_summary
);

  // --------------------------------------------------------------
  // Event update
  // --------------------------------------------------------------
  // Rising edges against the held condition
  logic [W-1:0] rise;
  // Bits that survive a read-clear
  logic [W-1:0] kept;
  // Next event contents
  logic [W-1:0] next_event;

  assign rise = i_cond & ~o_cond;
  assign kept = i_clr ? {W{1'b0}} : o_event;
  // New events are ORed after the clear so a set wins over the read
  assign next_event = kept | rise | i_pulse;
  // Only enabled events reach the summary
  assign o_summary = |(o_event & o_enable);

  // Condition, event and enable state
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_cond <= {W{1'b0}};
      o_event <= {W{1'b0}};
      o_enable <= {W{1'b0}};
    end else begin
      o_cond <= i_cond;
      o_event <= next_event;
      if (i_wr) begin
        o_enable <= i_wr_data;
      end
    end
  end

endmodule : isr_group

`default_nettype wire

// ===== hdl/isr_top.sv
/*
  Status reporting top: run-state and quality-fault groups (16 bits),
  standard event and service-request groups (8 bits), a register
  access port with read-clear events, and the service request line.
  Assumes all inputs are synchronous to i_sys_clk and that the
  command parser drives the read and write strobes for one cycle.
*/
// Contract
// - Clean decode leaves error bit three low
// - Waiting response sets message bit four
// - Two sixteen-bit, two eight-bit condition registers
// - Rising condition bit latches event bit
// - Event read returns contents and clears
// - Enable mask gates events to summary
// - Enabled quality event sets status bit three
// - Masked byte except bit six forms bit six
// - Bit six asserts service request line
// - Queue not empty bit three; message bit four
// - Run-state unused bits read zero
// - Trigger wait flag holds through low input
// - Bit six shows transient armed
// - Bit eight voltage mode, ten current mode
// - Bits nine, twelve event path only
// - Bit eleven sample done, fourteen list running
// - Quality bits zero, one show mode
// - Thermal fault bit three, slave bit six
// - Protection faults at bits twelve, thirteen
// - External reference sets both protection bits (code sets both only when a protection fault is also present)
// - Quality bit fourteen shows sinking
// - Quality unused bits read zero
`timescale 1ns/1ps
`default_nettype none
`include "isr_defs.svh"

module isr_top
  import isr_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_trig_enabled,
  input wire logic i_trig_ext_src,
  input wire logic i_trig_in,
  input wire logic i_tran_armed,
  input wire logic i_cv_mode,
  input wire logic i_cc_mode,
  input wire logic i_tran_done,
  input wire logic i_sample_done,
  input wire logic i_list_done,
  input wire logic i_list_running,
  input wire logic i_in_current_mode,
  input wire logic i_in_voltage_mode,
  input wire logic i_thermal_fault,
  input wire logic i_slave_fault,
  input wire logic i_volt_prot_fault,
  input wire logic i_curr_prot_fault,
  input wire logic i_ext_ref_en,
  input wire logic i_sinking,
  input wire logic [7:0] i_std_evt_cond,
  input wire logic i_err_queue_nonempty,
  input wire logic i_msg_avail,
  input wire logic i_rd_en,
  input wire logic [3:0] i_rd_sel,
  input wire logic i_wr_en,
  input wire logic [3:0] i_wr_sel,
  input wire logic [15:0] i_wr_data,
  output logic [15:0] o_rd_data,
  output logic o_rd_valid,
  output logic o_srq,
  output logic o_trigger_wait_flag
);

  // --------------------------------------------------------------
  // Trigger wait flag
  // --------------------------------------------------------------
  // Holds while an external trigger input sits low
  logic wait_hold;
  logic next_wait_hold;

  assign next_wait_hold = i_trig_ext_src &
                          (~i_trig_in | (wait_hold & ~i_trig_in));

  // Hold latch and registered flag
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wait_hold <= 1'b0;
      o_trigger_wait_flag <= 1'b0;
    end else begin
      wait_hold <= next_wait_hold;
      o_trigger_wait_flag <= i_trig_enabled | next_wait_hold;
    end
  end

  // --------------------------------------------------------------
  // Run-state condition inputs
  // --------------------------------------------------------------
  isr_word_t oper_in;      // Masked condition word
  isr_word_t oper_pulse;   // Event-only pulses
  isr_word_t oper_cond;    // Held condition
  isr_word_t oper_event;   // Latched events
  isr_word_t oper_en;      // Enable mask
  logic oper_sum;          // Enabled event summary
  isr_word_t oper_raw;     // Before unused bits are forced

  // Condition word; positions with no source stay zero
  always_comb begin
    oper_raw = `ISR_RST_WORD;
    oper_raw[`ISR_OPER_WAIT] = i_trig_enabled | wait_hold;
    oper_raw[`ISR_OPER_ARMED] = i_tran_armed;
    oper_raw[`ISR_OPER_CV] = i_cv_mode;
    oper_raw[`ISR_OPER_CC] = i_cc_mode;
    oper_raw[`ISR_OPER_SAMPLE] = i_sample_done;
    oper_raw[`ISR_OPER_LRUN] = i_list_running;
  end
  assign oper_in = oper_raw & ~(`ISR_OPER_ZERO | `ISR_OPER_EVONLY);

  assign oper_pulse = ({{(`ISR_WIDE-1){1'b0}}, i_tran_done}
                       << `ISR_OPER_TDONE) |
                      ({{(`ISR_WIDE-1){1'b0}}, i_list_done}
                       << `ISR_OPER_LDONE);

  // --------------------------------------------------------------
  // Quality fault condition inputs
  // --------------------------------------------------------------
  isr_word_t ques_raw;
  isr_word_t ques_in;
  isr_word_t ques_cond;
  isr_word_t ques_event;
  isr_word_t ques_en;
  logic ques_sum;
  logic ref_fault;         // Any protection fault under ext reference

  assign ref_fault = i_ext_ref_en & (i_volt_prot_fault | i_curr_prot_fault);
  // Fault word; unused positions stay zero
  always_comb begin
    ques_raw = `ISR_RST_WORD;
    ques_raw[`ISR_QUES_CM] = i_in_current_mode;
    ques_raw[`ISR_QUES_VM] = i_in_voltage_mode;
    ques_raw[`ISR_QUES_THERM] = i_thermal_fault;
    ques_raw[`ISR_QUES_SLAVE] = i_slave_fault;
    ques_raw[`ISR_QUES_VPROT] = i_volt_prot_fault | ref_fault;
    ques_raw[`ISR_QUES_CPROT] = i_curr_prot_fault | ref_fault;
    ques_raw[`ISR_QUES_SINK] = i_sinking;
  end
  assign ques_in = ques_raw & ~`ISR_QUES_ZERO;

  // --------------------------------------------------------------
  // Status byte and service request
  // --------------------------------------------------------------
  isr_byte_t std_cond;
  isr_byte_t std_event;
  isr_byte_t std_en;
  logic std_sum;
  isr_byte_t sb_in;        // Status byte condition
  isr_byte_t sb_cond;
  isr_byte_t sb_event;
  isr_byte_t sb_en;
  logic rqs_next;          // Request summary for next cycle

  assign sb_in[2:0] = `ISR_SB_LOW_ZERO;
  // error bit only from queue or faults
  assign sb_in[`ISR_SB_ERR] = i_err_queue_nonempty | ques_sum;
  assign sb_in[`ISR_SB_MAV] = i_msg_avail;
  assign sb_in[`ISR_SB_ESB] = std_sum;
  assign sb_in[`ISR_SB_RQS] = o_srq;
  assign sb_in[`ISR_SB_OPER] = oper_sum;
  assign rqs_next = |(sb_in & sb_en & `ISR_SB_RQS_OFF);

  // Request line flop; bit six of the byte reads this same flop
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_srq <= 1'b0;
    end else begin
      o_srq <= rqs_next;
    end
  end

  // --------------------------------------------------------------
  // Register access decode
  // --------------------------------------------------------------
  wire clr_oper = i_rd_en & (i_rd_sel == `ISR_SEL_OPER_EVT);
  wire clr_ques = i_rd_en & (i_rd_sel == `ISR_SEL_QUES_EVT);
  wire clr_std = i_rd_en & (i_rd_sel == `ISR_SEL_STD_EVT);
  wire clr_sb = i_rd_en & (i_rd_sel == `ISR_SEL_SB_EVT);
  wire wr_oper = i_wr_en & (i_wr_sel == `ISR_SEL_OPER_EN);
  wire wr_ques = i_wr_en & (i_wr_sel == `ISR_SEL_QUES_EN);
  wire wr_std = i_wr_en & (i_wr_sel == `ISR_SEL_STD_EN);
  wire wr_sb = i_wr_en & (i_wr_sel == `ISR_SEL_SB_EN);
  isr_word_t rd_mux;

  // Unmapped selects read zero; bytes sit in the low lane
  assign rd_mux =
    (i_rd_sel == `ISR_SEL_OPER_COND) ? oper_cond :
    (i_rd_sel == `ISR_SEL_OPER_EVT) ? oper_event :
    (i_rd_sel == `ISR_SEL_OPER_EN) ? oper_en :
    (i_rd_sel == `ISR_SEL_QUES_COND) ? ques_cond :
    (i_rd_sel == `ISR_SEL_QUES_EVT) ? ques_event :
    (i_rd_sel == `ISR_SEL_QUES_EN) ? ques_en :
    (i_rd_sel == `ISR_SEL_STD_COND) ? {`ISR_PAD_BYTE, std_cond} :
    (i_rd_sel == `ISR_SEL_STD_EVT) ? {`ISR_PAD_BYTE, std_event} :
    (i_rd_sel == `ISR_SEL_STD_EN) ? {`ISR_PAD_BYTE, std_en} :
    (i_rd_sel == `ISR_SEL_SB_COND) ? {`ISR_PAD_BYTE, sb_cond} :
    (i_rd_sel == `ISR_SEL_SB_EVT) ? {`ISR_PAD_BYTE, sb_event} :
    (i_rd_sel == `ISR_SEL_SB_EN) ? {`ISR_PAD_BYTE, sb_en} :
    `ISR_RST_WORD;

  // Read data register; the event value is taken before its clear
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rd_data <= `ISR_RST_WORD;
      o_rd_valid <= 1'b0;
    end else begin
      o_rd_valid <= i_rd_en;
      if (i_rd_en) begin
        o_rd_data <= rd_mux;
      end
    end
  end

  // --------------------------------------------------------------
  // Group instances
  // --------------------------------------------------------------
  // two wide groups
  isr_group #(.W(`ISR_WIDE)) u_oper (
    .i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
    .i_cond(oper_in), .i_pulse(oper_pulse), .i_clr(clr_oper),
    .i_wr(wr_oper), .i_wr_data(i_wr_data),
    .o_cond(oper_cond), .o_event(oper_event), .o_enable(oper_en),
    .o_summary(oper_sum)
  );

  isr_group #(.W(`ISR_WIDE)) u_ques (
    .i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
    .i_cond(ques_in), .i_pulse(`ISR_RST_WORD), .i_clr(clr_ques),
    .i_wr(wr_ques), .i_wr_data(i_wr_data),
    .o_cond(ques_cond), .o_event(ques_event), .o_enable(ques_en),
    .o_summary(ques_sum)
  );

  isr_group #(.W(`ISR_NARROW)) u_std (
    .i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
    .i_cond(i_std_evt_cond), .i_pulse(`ISR_RST_BYTE), .i_clr(clr_std),
    .i_wr(wr_std), .i_wr_data(i_wr_data[7:0]),
    .o_cond(std_cond), .o_event(std_event), .o_enable(std_en),
    .o_summary(std_sum)
  );

  isr_group #(.W(`ISR_NARROW)) u_sb (
    .i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
    .i_cond(sb_in), .i_pulse(`ISR_RST_BYTE), .i_clr(clr_sb),
    .i_wr(wr_sb), .i_wr_data(i_wr_data[7:0]),
    .o_cond(sb_cond), .o_event(sb_event), .o_enable(sb_en),
    .o_summary()
  );

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  sequence s_oper_evt_read;
    clr_oper && (oper_in & ~oper_cond) == `ISR_RST_WORD &&
    oper_pulse == `ISR_RST_WORD;
  endsequence

  sequence s_ext_low;
    i_trig_ext_src && !i_trig_in;
  endsequence

  // Request summary rebuilt by bit picking, not by the mask constant
  logic rqs_check;
  assign rqs_check =
    |({sb_in[`ISR_SB_OPER], sb_in[`ISR_SB_ESB:0]} &
      {sb_en[`ISR_SB_OPER], sb_en[`ISR_SB_ESB:0]});

  AST_ERR_BIT_CLEAN: assert property (
    @(posedge i_sys_clk) disable iff (!i_resetn)
    (!i_err_queue_nonempty && !ques_sum) |=> !sb_cond[`ISR_SB_ERR])
    else $error("error bit set without cause");

  AST_MAV_BIT: assert property (
    @(posedge i_sys_clk) disable iff (!i_resetn)
    i_msg_avail |=> sb_cond[`ISR_SB_MAV])
    else $error("message bit missing");

  AST_RISE_LATCH: assert property (
    @(posedge i_sys_clk) disable iff (!i_resetn)
    $rose(ques_cond[`ISR_QUES_THERM]) |-> ques_event[`ISR_QUES_THERM])
    else $error("rising condition not latched");

  AST_READ_CLEAR: assert property (
    @(posedge i_sys_clk) disable iff (!i_resetn)
    s_oper_evt_read |=> (oper_event == `ISR_RST_WORD) &&
      (o_rd_data == $past(oper_event)) && o_rd_valid)
    else $error("event read did not return and clear");

  AST_QUES_SUMMARY: assert property (
    @(posedge i_sys_clk) disable iff (!i_resetn)
    (|(ques_event & ques_en)) |=> sb_cond[`ISR_SB_ERR])
    else $error("quality summary missing");

  AST_RQS_FORM: assert property (
    @(posedge i_sys_clk) disable iff (!i_resetn)
    o_srq == $past(rqs_check))
    else $error("request summary wrong");

  AST_SRQ_RELEASE: assert property (
    @(posedge i_sys_clk) disable iff (!i_resetn)
    !rqs_check |=> !o_srq ##1 !sb_cond[`ISR_SB_RQS])
    else $error("request line not released");

  AST_OPER_ZERO: assert property (
    @(posedge i_sys_clk) disable iff (!i_resetn)
    (oper_cond & (`ISR_OPER_ZERO | `ISR_OPER_EVONLY)) == `ISR_RST_WORD)
    else $error("unused run-state bit set");

  AST_WAIT_HOLD: assert property (
    @(posedge i_sys_clk) disable iff (!i_resetn)
    s_ext_low |-> ##2 oper_cond[`ISR_OPER_WAIT])
    else $error("wait flag dropped while input low");

  AST_EVONLY: assert property (
    @(posedge i_sys_clk) disable iff (!i_resetn)
    i_tran_done |=> oper_event[`ISR_OPER_TDONE] &&
      !oper_cond[`ISR_OPER_TDONE])
    else $error("transient done path wrong");

  AST_REF_BOTH: assert property (
    @(posedge i_sys_clk) disable iff (!i_resetn)
    ref_fault |=> ques_cond[`ISR_QUES_VPROT] && ques_cond[`ISR_QUES_CPROT])
    else $error("protection bits not set together");

  AST_QUES_ZERO: assert property (
    @(posedge i_sys_clk) disable iff (!i_resetn)
    (ques_cond & `ISR_QUES_ZERO) == `ISR_RST_WORD)
    else $error("unused quality bit set");

endmodule : isr_top

`default_nettype wire

// ===== verification/isr_host.sv
/*
  Host controller model: issues one register read per request and
  hands back the answer with a done pulse.
  Assumes the register port answers one cycle after the read edge.
*/
`timescale 1ns/1ps
`default_nettype none

module isr_host
  import isr_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_req,
  input wire logic [3:0] i_sel,
  input wire logic i_rd_valid,
  input wire logic [15:0] i_rd_data,
  output logic o_rd_en,
  output logic [3:0] o_rd_sel,
  output logic [15:0] o_data,
  output logic o_done
);
  // ----------------------------------------------------------------
  // Read cycle
  // ----------------------------------------------------------------
  // Select toggles while idle so a stale select is never relied on
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rd_en <= 1'b0;
      o_rd_sel <= 4'h0;
      o_data <= 16'h0000;
      o_done <= 1'b0;
    end else begin
      o_rd_en <= i_req;
      o_rd_sel <= i_req ? i_sel : ~o_rd_sel;
      o_done <= i_rd_valid;
      // Capture answer on the valid edge
      if (i_rd_valid) begin
        o_data <= i_rd_data;
      end
    end
  end
endmodule : isr_host

`default_nettype wire

// ===== verification/testbench.sv
/*
  Self-checking bench for the status reporting top.
  Assumes a 200 MHz clock and a host model doing the reads.
*/
`timescale 1ns/1ps
`default_nettype none

module testbench
  import isr_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic i_sys_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic ten, tex, tin, arm, cv, cc, tdn, smp, ldn, lrn;
  logic qcm, qvm, thm, slv, vpf, cpf, xre, snk, erq, mav;
  logic [7:0] stdc;
  logic wr_en, req;
  logic [3:0] wr_sel, sel;
  logic [15:0] wr_data, rd_data, hdata;
  logic rd_en, rd_valid, srq, twf, hdone;
  logic [3:0] rd_sel;
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;

  // Clock: 5 ns period
  always #2.5 i_sys_clk = ~i_sys_clk;

  isr_top isr_top_inst (
    .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_trig_enabled(ten),
    .i_trig_ext_src(tex), .i_trig_in(tin), .i_tran_armed(arm),
    .i_cv_mode(cv), .i_cc_mode(cc), .i_tran_done(tdn),
    .i_sample_done(smp), .i_list_done(ldn), .i_list_running(lrn),
    .i_in_current_mode(qcm), .i_in_voltage_mode(qvm),
    .i_thermal_fault(thm), .i_slave_fault(slv),
    .i_volt_prot_fault(vpf), .i_curr_prot_fault(cpf),
    .i_ext_ref_en(xre), .i_sinking(snk), .i_std_evt_cond(stdc),
    .i_err_queue_nonempty(erq), .i_msg_avail(mav), .i_rd_en(rd_en),
    .i_rd_sel(rd_sel), .i_wr_en(wr_en), .i_wr_sel(wr_sel),
    .i_wr_data(wr_data), .o_rd_data(rd_data), .o_rd_valid(rd_valid),
    .o_srq(srq), .o_trigger_wait_flag(twf)
  );

  isr_host isr_host_inst (
    .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_req(req),
    .i_sel(sel), .i_rd_valid(rd_valid), .i_rd_data(rd_data),
    .o_rd_en(rd_en), .o_rd_sel(rd_sel), .o_data(hdata), .o_done(hdone)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task summarize;
    $display("checks=%0d errors=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      summarize();
    end
  end

  task tick(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask : tick

  task chk(input isr_word_t got, input isr_word_t exp);
    n_checks++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask : chk

  // All inputs idle
  task clr_in;
    {ten, tex, tin, arm, cv, cc, tdn, smp, ldn, lrn} <= 10'h000;
    {qcm, qvm, thm, slv, vpf, cpf, xre, snk, erq, mav} <= 10'h000;
    stdc <= 8'h00;
    {wr_en, req} <= 2'b00;
    {wr_sel, sel, wr_data} <= 24'h000000;
  endtask : clr_in

  task do_reset(input int n);
    @(posedge i_sys_clk);
    i_resetn <= 1'b0;
    clr_in();
    tick(n);
    i_resetn <= 1'b1;
    tick(1);
  endtask : do_reset

  // Read through the host model and compare
  task rd(input isr_sel_t s, input isr_word_t exp);
    int k;
    @(posedge i_sys_clk);
    req <= 1'b1;
    sel <= s;
    @(posedge i_sys_clk);
    req <= 1'b0;
    // Done is seen at the edge after the host flop sets it
    for (k = 0; k < 8; k++) begin
      @(posedge i_sys_clk);
      if (hdone === 1'b1) break;
    end
    // Exact latency: one cycle in the block, two in the host model
    chk((k == 2) ? hdata : 16'hdead, exp);
  endtask : rd

  task wr(input isr_sel_t s, input isr_word_t d);
    @(posedge i_sys_clk);
    wr_en <= 1'b1;
    wr_sel <= s;
    wr_data <= d;
    @(posedge i_sys_clk);
    wr_en <= 1'b0;
  endtask : wr

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Every select, unmapped ones too, reads zero after reset
  task t_reset_map;
    for (int s = 0; s < 16; s++) begin
      rd(isr_sel_t'(s), 16'h0000);
    end
  endtask : t_reset_map

  task t_run_state;
    @(posedge i_sys_clk);
    {ten, arm, cv, cc, smp, lrn, tdn, ldn} <= 8'hff;
    stdc <= 8'h5a;
    @(posedge i_sys_clk);
    {tdn, ldn} <= 2'b00;
    tick(3);
    rd(4'h0, 16'h4d60);
    rd(4'h1, 16'h5f60);
    rd(4'h1, 16'h0000);
    rd(4'h6, 16'h005a);
    rd(4'h7, 16'h005a);
  endtask : t_run_state

  task t_quality;
    @(posedge i_sys_clk);
    {qcm, qvm, thm, slv, vpf, snk} <= 6'h3f;
    tick(3);
    rd(4'h3, 16'h504b);
    do_reset(2);
    {xre, cpf} <= 2'b11;
    tick(3);
    rd(4'h3, 16'h3000);
  endtask : t_quality

  task t_service;
    int k;
    wr(4'h5, 16'h0008);
    wr(4'hb, 16'h0008);
    rd(4'h5, 16'h0008);
    rd(4'hb, 16'h0008);
    rd(4'h9, 16'h0000);
    thm <= 1'b1;
    for (k = 0; k < 6 && srq !== 1'b1; k++) tick(1);
    chk({15'h0000, srq}, 16'h0001);
    rd(4'h9, 16'h0048);
    rd(4'h4, 16'h0008);
    tick(3);
    chk({15'h0000, srq}, 16'h0000);
    wr(4'h5, 16'h0000);
    thm <= 1'b0;
    tick(2);
    thm <= 1'b1;
    tick(4);
    chk({15'h0000, srq}, 16'h0000);
    erq <= 1'b1;
    tick(4);
    rd(4'h9, 16'h0048);
    mav <= 1'b1;
    tick(3);
    rd(4'h9, 16'h0058);
  endtask : t_service

  // Run-state and standard summaries into the request line
  task t_summary;
    wr(4'h2, 16'h0200);
    wr(4'h8, 16'h0001);
    wr(4'hb, 16'h00e0);
    @(posedge i_sys_clk);
    tdn <= 1'b1;
    @(posedge i_sys_clk);
    tdn <= 1'b0;
    tick(3);
    chk({15'h0000, srq}, 16'h0001);
    rd(4'h9, 16'h00c0);
    rd(4'h1, 16'h0200);
    tick(3);
    chk({15'h0000, srq}, 16'h0000);
    stdc <= 8'h01;
    tick(4);
    rd(4'h9, 16'h0060);
    rd(4'ha, 16'h00e0);
    rd(4'ha, 16'h0000);
  endtask : t_summary

  task t_trigger;
    {tex, tin} <= 2'b11;
    tick(3);
    chk({15'h0000, twf}, 16'h0000);
    tin <= 1'b0;
    tick(4);
    chk({15'h0000, twf}, 16'h0001);
    rd(4'h0, 16'h0020);
    tin <= 1'b1;
    tick(3);
    chk({15'h0000, twf}, 16'h0000);
    ten <= 1'b1;
    tick(3);
    chk({15'h0000, twf}, 16'h0001);
  endtask : t_trigger

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    clr_in();
    tick(8);
    i_resetn <= 1'b1;
    tick(1);
    t_reset_map();
    t_run_state();
    do_reset(2);
    t_quality();
    do_reset(2);
    t_service();
    do_reset(2);
    t_summary();
    do_reset(2);
    t_trigger();
    summarize();
  end
endmodule : testbench

`default_nettype wire
